// ==== hw/tdsl_pkg.sv ====
// Shared constants and types for the torque direction and speed limit block
package tdsl_pkg;

   // Width of every speed figure, one count per 0.1 Hz
   localparam int FW = 16;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FWD_LIM = 8'h04;
   localparam logic [7:0] ADDR_REV_LIM = 8'h08;
   localparam logic [7:0] ADDR_MAX_FREQ = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_LIMIT = 8'h14;

   // Control register field positions
   localparam int CTRL_TENS_REV_BIT = 0;
   localparam int CTRL_TRQ_REV_BIT = 1;
   localparam int CTRL_SRC_LSB = 4;
   localparam int CTRL_METHOD_LSB = 8;

   // Status register field positions
   localparam int STAT_DIR_REV_BIT = 0;
   localparam int STAT_DIR_VALID_BIT = 1;
   localparam int STAT_OVERRIDE_BIT = 2;
   localparam int STAT_POWER_BIT = 3;
   localparam int STAT_MODE_LSB = 4;
   localparam int STAT_FWD_BIT = 8;
   localparam int STAT_REV_BIT = 9;
   localparam int STAT_TMODE_BIT = 10;

   // Frequency figures in 0.1 Hz counts
   localparam logic [FW-1:0] FREQ_400HZ = 16'h0fa0;
   localparam logic [FW-1:0] REV_FOLLOWS_FWD = 16'h270f;

   // Values after reset
   localparam logic FLAG_RST = 1'b0;
   localparam logic [FW-1:0] RST_FWD_LIM = 16'h0258;
   localparam logic [FW-1:0] RST_REV_LIM = REV_FOLLOWS_FWD;
   localparam logic [FW-1:0] RST_MAX_FREQ = 16'h0258;

   // Limit value sources
   localparam logic [1:0] SRC_SPEED_CMD = 2'h0;
   localparam logic [1:0] SRC_SETTINGS = 2'h1;
   localparam logic [1:0] SRC_ANALOG = 2'h2;

   // Limit method codes
   localparam logic [3:0] METHOD_M2 = 4'h0;
   localparam logic [3:0] METHOD_M3 = 4'h1;
   localparam logic [3:0] METHOD_M4 = 4'h2;
   localparam logic [3:0] METHOD_EXT = 4'ha;

   // Effective speed limit mode
   typedef enum logic [1:0] {MODE2, MODE3, MODE4} limit_mode_type;

endpackage : tdsl_pkg

// ==== hw/speed_limit_select.sv ====
// Limit magnitude selection and maximum frequency clamp
module speed_limit_select
   import tdsl_pkg::*;
#(
   parameter int W = FW
)
(
   // Settings
   input wire logic [1:0] i_source,
   input wire logic [W-1:0] i_fwd_setting,
   input wire logic [W-1:0] i_rev_setting,
   input wire logic [W-1:0] i_max_freq,
   input wire logic i_vector_ctrl,
   // Live values
   input wire logic signed [W-1:0] i_speed_cmd,
   input wire logic signed [W-1:0] i_analog,
   // Magnitudes for each side
   output logic [W-1:0] o_fwd_mag,
   output logic [W-1:0] o_rev_mag
);

   // Magnitude of a signed figure; the most negative code saturates
   function automatic logic [W-1:0] mag(input logic signed [W-1:0] v);
      logic [W-1:0] m;
      m = v[W-1] ? W'(-v) : W'(v);
      if (m[W-1])
      begin
         m = {1'b0, {(W-1){1'b1}}};
      end
      return m;
   endfunction : mag

   // Clamp a magnitude to a ceiling
   function automatic logic [W-1:0] clamp(input logic [W-1:0] v, input logic [W-1:0] c);
      return (v > c) ? c : v;
   endfunction : clamp

   logic [W-1:0] ceiling;
   logic [W-1:0] rev_setting_eff;
   logic [W-1:0] fwd_raw;
   logic [W-1:0] rev_raw;

   // Vector control never lets the ceiling pass 400 Hz
   assign ceiling = (i_vector_ctrl && i_max_freq > W'(FREQ_400HZ)) ? W'(FREQ_400HZ) : i_max_freq; // see R12

   // Reserved reverse value hands the reverse side to the forward setting
   assign rev_setting_eff = (i_rev_setting == W'(REV_FOLLOWS_FWD)) ? i_fwd_setting // see R8
                          : i_rev_setting;

   // Source of the limit value
   always_comb
   begin
      fwd_raw = i_fwd_setting; // see R7
      rev_raw = rev_setting_eff;
      unique case (i_source)
         SRC_SPEED_CMD:
         begin
            fwd_raw = mag(i_speed_cmd); // see R6
         end
         SRC_ANALOG:
         begin
            // Polarity of terminal 1 picks the side it limits
            if (i_analog[W-1])
            begin
               rev_raw = mag(i_analog); // see R6
            end
            else
            begin
               fwd_raw = mag(i_analog);
            end
         end
         default:
         begin
            fwd_raw = i_fwd_setting; // see R6
         end
      endcase
   end

   assign o_fwd_mag = clamp(fwd_raw, ceiling); // see R12
   assign o_rev_mag = clamp(rev_raw, ceiling); // see R12

endmodule : speed_limit_select

// ==== hw/torque_direction_speed_limit.sv ====
// Torque direction and speed limit decision logic with AHB-Lite registers

// Notes on behaviour
// R1: Tension reverse at 0 keeps the tension direction and at 1 inverts it, resetting to 0.
// R2: Torque command reverse at 0 keeps the direction and at 1 inverts it under reverse start.
// R3: In sensorless torque control the direction comes from the start command and both settings.
// R4: The operator may swap winding sides by these settings and by swapping the starts.
// R5: In torque control reaching or passing the active limit hands over to speed control.
// R6: The limit source picks the speed command, the two settings, or terminal 1 by polarity.
// R7: The forward limit takes 0 to 400 Hz, defaults to 60 Hz and limits the forward side.
// R8: The reverse limit takes 0 to 400 Hz, and its default 9999 means use the forward limit.
// R9: Method 0 is mode 2, 1 is mode 3, 2 is mode 4, and 10 picks 3 or 4 from the input.
// R10: In mode 2 the limit sign follows the torque command sign, zero counting as positive.
// R11: In mode 2 rotation against the torque polarity uses the reverse side limit.
// R12: Both limits are clamped to the maximum frequency, itself at most 400 Hz under vector.
// R13: Mode 3 serves positive torque, with forward start powering and reverse regenerating.
// R14: Mode 4 serves negative torque, with forward start regenerating and reverse powering.
// R15: In modes 3 and 4 a negative torque command applies the reverse side limit.
// R16: With the analog source, terminal 1 must also be given the speed limit function.
module torque_direction_speed_limit
   import tdsl_pkg::*;
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // AHB-Lite slave
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   // Start and mode pins
   input wire logic I_FORWARD_START_CMD,
   input wire logic I_REVERSE_START_CMD,
   input wire logic I_TORQUE_MODE_SELECT_INPUT,
   // Control loop state
   input wire logic I_TENSION_SENSORLESS,
   input wire logic I_TORQUE_CTRL,
   input wire logic I_VECTOR_CTRL,
   input wire logic signed [FW-1:0] I_SPEED_CMD,
   input wire logic signed [FW-1:0] I_ANALOG_T1,
   input wire logic signed [FW-1:0] I_TORQUE_CMD,
   input wire logic signed [FW-1:0] I_MOTOR_SPEED,
   // Decisions for the control loop
   output logic O_TORQUE_DIR_REV,
   output logic O_TORQUE_DIR_VALID,
   output logic O_POWER_DRIVING,
   output logic signed [FW-1:0] O_SPEED_LIMIT,
   output logic O_SPEED_CTRL_OVERRIDE,
   output logic [1:0] O_LIMIT_MODE
);

   // Settings that software may write
   logic tension_reverse_sel_r;
   logic torque_cmd_reverse_sel_r;
   logic [1:0] speed_limit_source_sel_r;
   logic [3:0] limit_method_sel_r;
   logic [FW-1:0] forward_speed_limit_r;
   logic [FW-1:0] reverse_speed_limit_r;
   logic [FW-1:0] max_output_frequency_r;

   // Bus data phase state
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_r;
   logic addr_ok;
   logic [7:0] addr_lo;

   // Pin synchronisers
   logic [1:0] fwd_sync_r;
   logic [1:0] rev_sync_r;
   logic [1:0] tmode_sync_r;
   logic fwd_on;
   logic rev_on;
   logic tmode_on;

   // Decision state
   limit_mode_type mode;
   logic [FW-1:0] fwd_mag;
   logic [FW-1:0] rev_mag;
   logic signed [FW-1:0] limit_nxt;
   logic dir_rev_r;
   logic dir_valid_r;
   logic power_r;
   logic signed [FW-1:0] limit_r;
   logic override_r;
   logic reached;
   logic [31:0] status;

   // Limit magnitudes per side after source selection and clamp
   speed_limit_select #(
      .W(FW)
   ) u_select (
      .i_source(speed_limit_source_sel_r),
      .i_fwd_setting(forward_speed_limit_r),
      .i_rev_setting(reverse_speed_limit_r),
      .i_max_freq(max_output_frequency_r),
      .i_vector_ctrl(I_VECTOR_CTRL),
      .i_speed_cmd(I_SPEED_CMD),
      .i_analog(I_ANALOG_T1),
      .o_fwd_mag(fwd_mag),
      .o_rev_mag(rev_mag)
   );

   // Two flip-flops per pin; only the second stage is ever read
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         fwd_sync_r <= 2'h0;
         rev_sync_r <= 2'h0;
         tmode_sync_r <= 2'h0;
      end
      else
      begin
         fwd_sync_r <= {fwd_sync_r[0], I_FORWARD_START_CMD};
         rev_sync_r <= {rev_sync_r[0], I_REVERSE_START_CMD};
         tmode_sync_r <= {tmode_sync_r[0], I_TORQUE_MODE_SELECT_INPUT};
      end
   end

   assign fwd_on = fwd_sync_r[1];
   assign rev_on = rev_sync_r[1];
   assign tmode_on = tmode_sync_r[1];

   // Zero wait state slave, always OKAY
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_HRDATA = rdata_r;
   assign addr_ok = I_HSEL && I_HREADY && I_HTRANS[1];
   assign addr_lo = I_HADDR[7:0];

   // Capture write address phase; the data arrive one cycle later
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else
      begin
         wr_pend_r <= addr_ok && I_HWRITE;
         wr_addr_r <= addr_lo;
      end
   end

   // Read data are fetched in the address phase so they stand in the data phase
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         rdata_r <= 32'h0;
      end
      else if (addr_ok && !I_HWRITE)
      begin
         unique case (addr_lo)
            ADDR_CTRL:
               rdata_r <= 32'(tension_reverse_sel_r) << CTRL_TENS_REV_BIT
                        | 32'(torque_cmd_reverse_sel_r) << CTRL_TRQ_REV_BIT
                        | 32'(speed_limit_source_sel_r) << CTRL_SRC_LSB
                        | 32'(limit_method_sel_r) << CTRL_METHOD_LSB;
            ADDR_FWD_LIM: rdata_r <= 32'(forward_speed_limit_r);
            ADDR_REV_LIM: rdata_r <= 32'(reverse_speed_limit_r);
            ADDR_MAX_FREQ: rdata_r <= 32'(max_output_frequency_r);
            ADDR_STATUS: rdata_r <= status;
            ADDR_LIMIT: rdata_r <= 32'(unsigned'(limit_r));
            default: rdata_r <= 32'h0; // Unmapped reads as zero
         endcase
      end
   end

   // Settings; a write outside the accepted range leaves the old value in place
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         tension_reverse_sel_r <= FLAG_RST; // see R1
         torque_cmd_reverse_sel_r <= FLAG_RST; // see R2
         speed_limit_source_sel_r <= SRC_SPEED_CMD;
         limit_method_sel_r <= METHOD_M2; // see R9
         forward_speed_limit_r <= RST_FWD_LIM; // see R7
         reverse_speed_limit_r <= RST_REV_LIM; // see R8
         max_output_frequency_r <= RST_MAX_FREQ;
      end
      else if (wr_pend_r)
      begin
         unique case (wr_addr_r)
            ADDR_CTRL:
            begin
               tension_reverse_sel_r <= I_HWDATA[CTRL_TENS_REV_BIT];
               torque_cmd_reverse_sel_r <= I_HWDATA[CTRL_TRQ_REV_BIT];
               if (I_HWDATA[CTRL_SRC_LSB +: 2] <= SRC_ANALOG)
               begin
                  speed_limit_source_sel_r <= I_HWDATA[CTRL_SRC_LSB +: 2]; // see R6
               end
               if (I_HWDATA[CTRL_METHOD_LSB +: 4] <= METHOD_M4
                   || I_HWDATA[CTRL_METHOD_LSB +: 4] == METHOD_EXT)
               begin
                  limit_method_sel_r <= I_HWDATA[CTRL_METHOD_LSB +: 4]; // see R9
               end
            end
            ADDR_FWD_LIM:
            begin
               if (I_HWDATA[31:FW] == '0 && I_HWDATA[FW-1:0] <= FREQ_400HZ)
               begin
                  forward_speed_limit_r <= I_HWDATA[FW-1:0]; // see R7
               end
            end
            ADDR_REV_LIM:
            begin
               if (I_HWDATA[31:FW] == '0 && (I_HWDATA[FW-1:0] <= FREQ_400HZ
                   || I_HWDATA[FW-1:0] == REV_FOLLOWS_FWD))
               begin
                  reverse_speed_limit_r <= I_HWDATA[FW-1:0]; // see R8
               end
            end
            ADDR_MAX_FREQ:
            begin
               if (I_HWDATA[31:FW] == '0)
               begin
                  max_output_frequency_r <= I_HWDATA[FW-1:0];
               end
            end
            default:
            begin
               // Writes to read-only or unmapped words are dropped
            end
         endcase
      end
   end

   // Effective limit mode; method 10 follows the external torque mode input
   always_comb
   begin
      unique case (limit_method_sel_r)
         METHOD_M3: mode = MODE3; // see R9
         METHOD_M4: mode = MODE4;
         METHOD_EXT: mode = tmode_on ? MODE4 : MODE3; // see R9
         default: mode = MODE2;
      endcase
   end

   // Signed limit from mode, torque sign and direction of rotation
   always_comb
   begin
      limit_nxt = signed'(fwd_mag);
      unique case (mode)
         MODE2:
         begin
            // Rotation opposite to the torque polarity takes the reverse side
            if (!I_TORQUE_CMD[FW-1] && I_MOTOR_SPEED[FW-1])
            begin
               limit_nxt = -signed'(rev_mag); // see R11
            end
            else if (I_TORQUE_CMD[FW-1] && !I_MOTOR_SPEED[FW-1] && I_MOTOR_SPEED != '0)
            begin
               limit_nxt = signed'(rev_mag); // see R11
            end
            else if (I_TORQUE_CMD[FW-1])
            begin
               limit_nxt = -signed'(fwd_mag); // see R10
            end
            else
            begin
               limit_nxt = signed'(fwd_mag); // see R10
            end
         end
         default:
         begin
            // Modes 3 and 4: negative torque guards reverse rotation
            if (I_TORQUE_CMD[FW-1])
            begin
               limit_nxt = -signed'(rev_mag); // see R15
            end
            else
            begin
               limit_nxt = signed'(fwd_mag);
            end
         end
      endcase
   end

   // Limit reached when speed meets or passes it on the limit's side
   assign reached = limit_r[FW-1] ? (I_MOTOR_SPEED <= limit_r) // see R5
                                  : (I_MOTOR_SPEED >= limit_r);

   // Torque generation direction; both or neither start leaves no direction
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         dir_rev_r <= 1'b0;
         dir_valid_r <= 1'b0;
      end
      else
      begin
         dir_valid_r <= I_TENSION_SENSORLESS && (fwd_on ^ rev_on); // see R3
         dir_rev_r <= tension_reverse_sel_r // see R1
                    ^ (torque_cmd_reverse_sel_r && rev_on && !fwd_on); // see R2 R3 R4
      end
   end

   // Power or regenerative driving as each mode defines it
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         power_r <= 1'b0;
      end
      else
      begin
         unique case (mode)
            MODE3: power_r <= fwd_on && !rev_on; // see R13
            MODE4: power_r <= rev_on && !fwd_on; // see R14
            default: power_r <= !I_TORQUE_CMD[FW-1] ^ I_MOTOR_SPEED[FW-1];
         endcase
      end
   end

   // Limit register and hand-over to speed control; a cycle of lag is harmless
   // against the mechanical time constants of the roll
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         limit_r <= '0;
         override_r <= 1'b0;
      end
      else
      begin
         limit_r <= limit_nxt;
         override_r <= I_TORQUE_CTRL && reached; // see R5
      end
   end

   // Status word for software
   always_comb
   begin
      status = 32'h0;
      status[STAT_DIR_REV_BIT] = dir_rev_r;
      status[STAT_DIR_VALID_BIT] = dir_valid_r;
      status[STAT_OVERRIDE_BIT] = override_r;
      status[STAT_POWER_BIT] = power_r;
      status[STAT_MODE_LSB +: 2] = mode;
      status[STAT_FWD_BIT] = fwd_on;
      status[STAT_REV_BIT] = rev_on;
      status[STAT_TMODE_BIT] = tmode_on;
   end

   // Outputs
   assign O_TORQUE_DIR_REV = dir_rev_r;
   assign O_TORQUE_DIR_VALID = dir_valid_r;
   assign O_POWER_DRIVING = power_r;
   assign O_SPEED_LIMIT = limit_r;
   assign O_SPEED_CTRL_OVERRIDE = override_r;
   assign O_LIMIT_MODE = mode;

endmodule : torque_direction_speed_limit

// ==== verif/tdsl_asserts.sv ====
// Checker for the torque direction and speed limit block
module tdsl_asserts
   import tdsl_pkg::*;
(
   // Clock, reset and bus
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [31:0] I_HWDATA,
   // Pins and loop values
   input wire logic I_FORWARD_START_CMD,
   input wire logic I_REVERSE_START_CMD,
   input wire logic I_TORQUE_MODE_SELECT_INPUT,
   input wire logic I_TENSION_SENSORLESS,
   input wire logic I_TORQUE_CTRL,
   input wire logic I_VECTOR_CTRL,
   input wire logic signed [FW-1:0] I_TORQUE_CMD,
   input wire logic signed [FW-1:0] I_MOTOR_SPEED,
   // Decisions
   input wire logic O_TORQUE_DIR_REV,
   input wire logic O_TORQUE_DIR_VALID,
   input wire logic O_POWER_DRIVING,
   input wire logic signed [FW-1:0] O_SPEED_LIMIT,
   input wire logic O_SPEED_CTRL_OVERRIDE,
   input wire logic [1:0] O_LIMIT_MODE
);
   logic wr_r, tens_r, trq_r, tc_r;
   logic [3:0] meth_r, pins_r;
   logic [2:0] quiet_r;
   logic signed [FW-1:0] spd_r, lim_r;
   logic [1:0] mode_exp;
   wire logic [3:0] pins = {I_FORWARD_START_CMD, I_REVERSE_START_CMD,
      I_TORQUE_MODE_SELECT_INPUT, I_TENSION_SENSORLESS};

   default clocking dcb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);

   // Shadow of the control word; an illegal method code leaves the old one
   always_ff @(posedge I_CLK)
   begin
      wr_r <= I_RST_B & I_HSEL & I_HTRANS[1] & I_HWRITE & (I_HADDR[7:0] == ADDR_CTRL);
      if (!I_RST_B)
      begin
         tens_r <= 1'b0;
         trq_r <= 1'b0;
         meth_r <= 4'h0;
      end
      else if (wr_r)
      begin
         tens_r <= I_HWDATA[0];
         trq_r <= I_HWDATA[1];
         if (I_HWDATA[11:8] inside {4'h0, 4'h1, 4'h2, 4'ha})
            meth_r <= I_HWDATA[11:8];
      end
   end

   // Settle counter: outputs lag the pins by the sync chain, so wait it out
   always_ff @(posedge I_CLK)
   begin
      pins_r <= pins;
      tc_r <= I_TORQUE_CTRL;
      spd_r <= I_MOTOR_SPEED;
      lim_r <= O_SPEED_LIMIT;
      if (!I_RST_B || pins_r != pins || wr_r)
         quiet_r <= 3'h0;
      else if (quiet_r != 3'h7)
         quiet_r <= quiet_r + 3'h1;
   end

   // Expected mode from the shadowed method and the mode pin
   assign mode_exp = (meth_r == METHOD_M3) ? 2'h1 : (meth_r == METHOD_M4) ? 2'h2 :
      (meth_r == METHOD_EXT) ? (pins_r[1] ? 2'h2 : 2'h1) : 2'h0;

   dir_valid_a:
      assert property (quiet_r >= 3'h4 |-> O_TORQUE_DIR_VALID == (pins_r[0] & (pins_r[3] ^ pins_r[2])))
      else $error("direction valid flag wrong");
   dir_value_a:
      assert property (quiet_r >= 3'h4 && O_TORQUE_DIR_VALID |->
         O_TORQUE_DIR_REV == (tens_r ^ (trq_r & pins_r[2])))
      else $error("torque direction wrong");
   mode_sel_a:
      assert property (quiet_r >= 3'h4 |-> O_LIMIT_MODE == mode_exp)
      else $error("limit mode wrong");
   power_mode_a:
      assert property (quiet_r >= 3'h4 && O_LIMIT_MODE != 2'h0 |-> O_POWER_DRIVING ==
         (O_LIMIT_MODE == 2'h1 ? pins_r[3] & !pins_r[2] : pins_r[2] & !pins_r[3]))
      else $error("power driving flag wrong");
   override_a:
      assert property ($past(I_RST_B) |-> O_SPEED_CTRL_OVERRIDE ==
         (tc_r && (lim_r >= 0 ? spd_r >= lim_r : spd_r <= lim_r)))
      else $error("speed control override wrong");
   sign_follow_a:
      assert property ($past(I_RST_B) && $past(O_LIMIT_MODE) == 2'h0 &&
         !$past(I_TORQUE_CMD[FW-1]) && !$past(I_MOTOR_SPEED[FW-1]) |-> !O_SPEED_LIMIT[FW-1])
      else $error("limit sign does not follow torque");
   against_load_a:
      assert property ($past(I_RST_B) && $past(O_LIMIT_MODE) == 2'h0 &&
         !$past(I_TORQUE_CMD[FW-1]) && $past(I_MOTOR_SPEED[FW-1]) |-> O_SPEED_LIMIT <= 0)
      else $error("reverse side limit not applied");
   rev_side_a:
      assert property ($past(I_RST_B) && $past(O_LIMIT_MODE) != 2'h0 &&
         $past(I_TORQUE_CMD[FW-1]) |-> O_SPEED_LIMIT <= 0)
      else $error("negative torque limit not reverse side");
   clamp_a:
      assert property ($past(I_RST_B) && $past(I_VECTOR_CTRL) |->
         O_SPEED_LIMIT <= 16'sd4000 && O_SPEED_LIMIT >= -16'sd4000)
      else $error("limit beyond vector ceiling");
endmodule : tdsl_asserts

bind torque_direction_speed_limit tdsl_asserts u_chk (.*);

// ==== verif/loop_model.sv ====
// Behavioural model of the motor speed loop beyond the block
module loop_model
   import tdsl_pkg::*;
(
   // Clock and block decisions
   input wire logic i_clk,
   input wire logic i_override,
   input wire logic signed [FW-1:0] i_limit,
   // Speed the load would drive the motor to
   input wire logic signed [FW-1:0] i_speed_set,
   output logic signed [FW-1:0] o_motor_speed
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_motor_speed = '0;

   // Under speed control the loop pins the motor at the limit
   always @(posedge i_clk)
   begin
      if (i_override)
         o_motor_speed <= i_limit;
      else
         o_motor_speed <= i_speed_set;
   end
endmodule : loop_model

// ==== verif/tb_torque_direction_speed_limit.sv ====
// Self-checking bench for the torque direction and speed limit block
module tb_torque_direction_speed_limit
   import tdsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, rst_b = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, fwd = 1'b0, rev = 1'b0, tmode = 1'b0;
   logic sens = 1'b0, tctrl = 1'b0, vec = 1'b0;
   logic dir_rev, dir_valid, power, ovr;
   logic [1:0] lmode;
   logic signed [FW-1:0] spd_cmd = '0, analog = '0, torque = '0, spd_set = '0;
   logic signed [FW-1:0] mspeed, limit;
   int num_errors = 0, samples_checked = 0, cycles = 0;
   logic [7:0] addrs [5] = '{ADDR_CTRL, ADDR_FWD_LIM, ADDR_REV_LIM, ADDR_MAX_FREQ, 8'h18};
   logic [31:0] rstv [5] = '{32'h0, 32'h258, 32'h270f, 32'h258, 32'h0};
   logic [3:0] mcode [5] = '{METHOD_M2, METHOD_M3, METHOD_M4, METHOD_EXT, METHOD_EXT};
   logic [1:0] mexp [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};

   always #2.5 clk = ~clk;

   torque_direction_speed_limit DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_HSEL(1'b1),
      .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
      .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HRDATA(hrdata),
      .O_HREADYOUT(hreadyout), .O_HRESP(hresp), .I_FORWARD_START_CMD(fwd),
      .I_REVERSE_START_CMD(rev), .I_TORQUE_MODE_SELECT_INPUT(tmode),
      .I_TENSION_SENSORLESS(sens), .I_TORQUE_CTRL(tctrl), .I_VECTOR_CTRL(vec),
      .I_SPEED_CMD(spd_cmd), .I_ANALOG_T1(analog), .I_TORQUE_CMD(torque),
      .I_MOTOR_SPEED(mspeed), .O_TORQUE_DIR_REV(dir_rev), .O_TORQUE_DIR_VALID(dir_valid),
      .O_POWER_DRIVING(power), .O_SPEED_LIMIT(limit), .O_SPEED_CTRL_OVERRIDE(ovr),
      .O_LIMIT_MODE(lmode));

   loop_model u_loop (.i_clk(clk), .i_override(ovr), .i_limit(limit),
      .i_speed_set(spd_set), .o_motor_speed(mspeed));

   task automatic stop_test();
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask : chk

   // Single word transfer; each phase is held until hready is seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q, e);
      chk(hresp, 32'h0);
   endtask : rd

   // Apply torque and load speed, then compare the active limit
   task automatic lim(input int t, input int s, input int e);
      torque <= 16'(t);
      spd_set <= 16'(s);
      repeat (4) @(posedge clk);
      chk(limit, 16'(e));
   endtask : lim

   // Hang guard well beyond the few hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         num_errors++;
         stop_test();
      end
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
         rd(addrs[i], rstv[i]);
      wr(ADDR_FWD_LIM, 32'hfa1);
      rd(ADDR_FWD_LIM, 32'h258);
      wr(ADDR_REV_LIM, 32'hfa0);
      rd(ADDR_REV_LIM, 32'hfa0);
      // Direction for each setting pair under each start; operator swaps starts
      sens <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         wr(ADDR_CTRL, {30'h0, i[1:0]});
         fwd <= ~i[2];
         rev <= i[2];
         repeat (6) @(posedge clk);
         chk(dir_valid, 1'b1);
         chk(dir_rev, i[0] ^ (i[1] & i[2]));
      end
      fwd <= 1'b1;
      repeat (6) @(posedge clk);
      chk(dir_valid, 1'b0);
      fwd <= 1'b0;
      // Every method code, the external pin both ways
      for (int i = 0; i < 5; i++)
      begin
         wr(ADDR_CTRL, {20'h0, mcode[i], 8'h10});
         tmode <= (i == 4);
         repeat (6) @(posedge clk);
         chk(lmode, mexp[i]);
      end
      chk(power, 1'b1);
      // Status word: valid reverse-only start, mode 4, reverse and mode pins high
      rd(ADDR_STATUS, 32'h62a);
      // Mode 2, then mode 3, with the two settings as source
      wr(ADDR_CTRL, 32'h10);
      wr(ADDR_FWD_LIM, 32'h1f4);
      wr(ADDR_REV_LIM, 32'h270f);
      lim(100, 100, 500);
      lim(-100, -100, -500);
      lim(0, 0, 500);
      lim(100, -50, -500);
      wr(ADDR_REV_LIM, 32'h12c);
      lim(100, -50, -300);
      lim(-100, 50, 300);
      wr(ADDR_CTRL, 32'h110);
      lim(-100, 0, -300);
      // Forward-only start powers in mode 3 and regenerates in mode 4
      fwd <= 1'b1;
      rev <= 1'b0;
      lim(100, 0, 500);
      chk(power, 1'b1);
      wr(ADDR_CTRL, 32'h210);
      lim(-100, 0, -300);
      chk(power, 1'b0);
      rd(ADDR_LIMIT, 32'hfed4);
      // Speed command source, then terminal 1 by polarity
      spd_cmd <= 16'sd250;
      wr(ADDR_CTRL, 32'h100);
      lim(100, 0, 250);
      analog <= -16'sd200;
      wr(ADDR_CTRL, 32'h120);
      lim(-100, 0, -200);
      analog <= 16'sd200;
      lim(100, 0, 200);
      // Reaching the limit hands the loop to speed control
      wr(ADDR_CTRL, 32'h110);
      tctrl <= 1'b1;
      lim(100, 499, 500);
      chk(ovr, 1'b0);
      lim(100, 500, 500);
      chk(ovr, 1'b1);
      tctrl <= 1'b0;
      // Maximum frequency clamp, and the vector ceiling above it
      wr(ADDR_MAX_FREQ, 32'h190);
      lim(100, 0, 400);
      vec <= 1'b1;
      spd_cmd <= 16'sd4500;
      wr(ADDR_MAX_FREQ, 32'h1388);
      wr(ADDR_CTRL, 32'h100);
      lim(100, 0, 4000);
      stop_test();
   end
endmodule : tb_torque_direction_speed_limit
